// ==== verilog/cfs_flags_sp.v ====
// Condition code register and stack pointer of the core
// Notes on behaviour
// - Sign flag copies bit 7 of each ALU result.
// - Zero flag is one when the ALU result is zero.
// - Carry follows ALU overflow or borrow; set and clear ops write it.
// - Bit test, shift and rotate ops also update carry.
// - Priority pair codes: level0=10, level1=01, level2=00, level3=11.
// - Interrupt entry loads priority bits from the source's level regs.
// - Unmask, mask, return, halt, wait and cc pop may change priority.
// - Sixteen bit stack pointer addresses next free byte; resets 01FF.
// - Pointer decrements after each push, increments before each pop.
// - Upper pointer byte is fixed; only low byte varies.
// - Reset or reload op restores pointer with low byte all ones.
// - Low pointer byte can be loaded and read directly.
// - Pointer wraps silently at both stack limits.
// - Interrupt stores program counter low byte at first location.
// - Call uses two stack bytes, interrupt uses five.
// - Interrupt pushes context decrementing; return pops incrementing.
// - Second index register is never stacked.
// - Half carry set on carry from bit 3 in add and add-with-carry.
// - Condition register resets to 111x1xxx, priority disabled.
`timescale 1ns/1ns
`include "cfs_regs.vh"
module cfs_flags_sp (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        alu_valid,
  input  wire [7:0]  alu_result,
  input  wire        alu_carry_upd,
  input  wire        alu_carry,
  input  wire        alu_half_upd,
  input  wire        alu_half,
  input  wire        set_carry_op,
  input  wire        clear_carry_op,
  input  wire        prio_wr,
  input  wire [1:0]  prio_wr_val,
  input  wire        irq_enter,
  input  wire [1:0]  irq_level_regs,
  input  wire        cc_wr,
  input  wire [7:0]  cc_wr_data,
  input  wire        ptr_reload_op,
  input  wire        sp_low_wr,
  input  wire [7:0]  sp_low_data,
  input  wire        push_byte,
  input  wire        pop_byte,
  input  wire        call_start,
  input  wire        ret_start,
  input  wire        int_return_op,
  output reg  [7:0]  cond_code_reg,
  output reg  [15:0] stack_top_ptr,
  output reg  [15:0] stack_addr,
  output reg         stack_wr,
  output reg  [2:0]  ctx_sel,
  output reg         seq_busy
);

  localparam ST_IDLE = 2'b00;
  localparam ST_PUSH = 2'b01;
  localparam ST_POP  = 2'b10;

  reg [7:0] sp_low_reg;
  reg [7:0] sp_low_next;
  reg [7:0] cc_reg;
  reg [7:0] cc_next;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] cnt_reg;
  reg [2:0] cnt_next;
  reg [2:0] len_reg;
  reg [2:0] len_next;
  reg       seq_push;
  reg       seq_pop;
  reg       start_go;
  reg       start_pop;
  reg [2:0] start_len;
  reg       sign_next;
  reg       zero_next;
  reg       carry_next;
  reg       half_next;
  reg [1:0] prio_next;
  wire      last_byte;

  // Final byte of the running sequence
  assign last_byte = (cnt_reg == len_reg - 3'd1);

  // Start decode; interrupt entry outranks calls and returns
  always @* begin
    start_go  = 1'b0;
    start_pop = 1'b0;
    start_len = `CFS_CALL_BYTES;
    if (irq_enter) begin
      start_go  = 1'b1;
      start_len = `CFS_INT_BYTES;
    end else if (call_start) begin
      start_go  = 1'b1;
      start_len = `CFS_CALL_BYTES;
    end else if (int_return_op) begin
      start_go  = 1'b1;
      start_pop = 1'b1;
      start_len = `CFS_INT_BYTES;
    end else if (ret_start) begin
      start_go  = 1'b1;
      start_pop = 1'b1;
      start_len = `CFS_CALL_BYTES;
    end
  end

  // Sequencer steps one stack byte per cycle
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    len_next   = len_reg;
    seq_push   = 1'b0;
    seq_pop    = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = 3'd0;
        if (start_go) begin
          state_next = start_pop ? ST_POP : ST_PUSH;
          len_next   = start_len;
        end
      end
      ST_PUSH: begin
        seq_push = 1'b1;
        cnt_next = cnt_reg + 3'd1;
        if (last_byte) begin
          state_next = ST_IDLE;
        end
      end
      ST_POP: begin
        seq_pop  = 1'b1;
        cnt_next = cnt_reg + 3'd1;
        if (last_byte) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sign and zero follow every ALU result
  always @* begin
    sign_next = cc_reg[`CFS_CC_NEG];
    zero_next = cc_reg[`CFS_CC_ZERO];
    if (alu_valid) begin
      sign_next = alu_result[7];
      zero_next = (alu_result == 8'h00);
    end
  end

  // Carry; explicit set and clear ops beat the ALU
  always @* begin
    carry_next = cc_reg[`CFS_CC_CARRY];
    if (alu_carry_upd) begin
      carry_next = alu_carry;
    end
    if (set_carry_op) begin
      carry_next = 1'b1;
    end else if (clear_carry_op) begin
      carry_next = 1'b0;
    end
  end

  // Half carry only moves on add and add-with-carry
  always @* begin
    half_next = cc_reg[`CFS_CC_HALF];
    if (alu_half_upd) begin
      half_next = alu_half;
    end
  end

  // Software priority writes: unmask, mask, halt and wait ops
  always @* begin
    prio_next = {cc_reg[`CFS_CC_PRIO_HI], cc_reg[`CFS_CC_PRIO_LO]};
    if (prio_wr) begin
      prio_next = prio_wr_val;
    end
  end

  // Stack pointer low byte; 8-bit arithmetic gives the silent wrap
  always @* begin
    sp_low_next = sp_low_reg;
    if (ptr_reload_op) begin
      sp_low_next = `CFS_SP_LOW_RESET;
    end else if (sp_low_wr) begin
      sp_low_next = sp_low_data;
    end else if (push_byte || seq_push) begin
      sp_low_next = sp_low_reg - 8'h01;
    end else if (pop_byte || seq_pop) begin
      sp_low_next = sp_low_reg + 8'h01;
    end
  end

  // Condition code; events applied in ascending priority
  always @* begin
    cc_next = cc_reg;
    cc_next[7:6] = 2'b11;
    cc_next[`CFS_CC_NEG]     = sign_next;
    cc_next[`CFS_CC_ZERO]    = zero_next;
    cc_next[`CFS_CC_CARRY]   = carry_next;
    cc_next[`CFS_CC_HALF]    = half_next;
    cc_next[`CFS_CC_PRIO_HI] = prio_next[1];
    cc_next[`CFS_CC_PRIO_LO] = prio_next[0];
    if (cc_wr) begin
      cc_next = {2'b11, cc_wr_data[5:0]};
    end
    // Interrupt entry wins; cc is pushed later, as the fifth byte of the sequence
    if (irq_enter && state_reg == ST_IDLE) begin
      cc_next[`CFS_CC_PRIO_HI] = irq_level_regs[1];
      cc_next[`CFS_CC_PRIO_LO] = irq_level_regs[0];
    end
  end

  // Sequencer registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 3'd0;
      len_reg   <= 3'd0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      len_reg   <= len_next;
    end
  end

  // Low pointer byte
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sp_low_reg <= `CFS_SP_LOW_RESET;
    end else begin
      sp_low_reg <= sp_low_next;
    end
  end

  // Internal condition code
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cc_reg <= `CFS_CC_RESET;
    end else begin
      cc_reg <= cc_next;
    end
  end

  // Output copy kept separate so the port comes straight from a flop
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cond_code_reg <= `CFS_CC_RESET;
    end else begin
      cond_code_reg <= cc_next;
    end
  end

  // High byte is wired, so no write can move it off the stack page
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stack_top_ptr <= `CFS_SP_RESET;
    end else begin
      stack_top_ptr <= {`CFS_SP_HIGH, sp_low_next};
    end
  end

  // Pop reads at the incremented pointer, push writes at current one
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stack_addr <= `CFS_SP_RESET;
    end else if (seq_push) begin
      stack_addr <= {`CFS_SP_HIGH, sp_low_reg};
    end else begin
      stack_addr <= {`CFS_SP_HIGH, sp_low_next};
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stack_wr <= 1'b0;
    end else begin
      stack_wr <= seq_push;
    end
  end

  // Second index register is not in the context list at all
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctx_sel <= 3'd0;
    end else if (seq_push) begin
      ctx_sel <= cnt_reg;
    end else if (seq_pop) begin
      ctx_sel <= len_reg - 3'd1 - cnt_reg;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seq_busy <= 1'b0;
    end else begin
      seq_busy <= (state_next != ST_IDLE);
    end
  end

endmodule

// ==== verilog/cfs_regs.vh ====
// Constants for the condition flags and stack pointer block
`ifndef CFS_REGS_VH
`define CFS_REGS_VH
`define CFS_CC_CARRY      0
`define CFS_CC_ZERO       1
`define CFS_CC_NEG        2
`define CFS_CC_PRIO_LO    3
`define CFS_CC_HALF       4
`define CFS_CC_PRIO_HI    5
`define CFS_CC_RESET      8'hE8
`define CFS_SP_RESET      16'h01FF
`define CFS_SP_HIGH       8'h01
`define CFS_SP_LOW_RESET  8'hFF
`define CFS_PRIO_LVL0     2'b10
`define CFS_PRIO_LVL1     2'b01
`define CFS_PRIO_LVL2     2'b00
`define CFS_PRIO_LVL3     2'b11
`define CFS_CALL_BYTES    3'd2
`define CFS_INT_BYTES     3'd5
`define CFS_CTX_PCL       3'd0
`define CFS_CTX_PCH       3'd1
`define CFS_CTX_X         3'd2
`define CFS_CTX_A         3'd3
`define CFS_CTX_CC        3'd4
`endif

// ==== tb/cfs_flags_sp_monitor.sv ====
// Assertion checker for the flags and stack pointer block
`timescale 1ns/1ns
module cfs_flags_sp_monitor (
  input wire        ref_clk,
  input wire        rstn,
  input wire        alu_valid,
  input wire        set_carry_op,
  input wire        clear_carry_op,
  input wire        irq_enter,
  input wire        cc_wr,
  input wire        ptr_reload_op,
  input wire        stack_wr,
  input wire        seq_busy,
  input wire [7:0]  alu_result,
  input wire [7:0]  cond_code_reg,
  input wire [1:0]  irq_level_regs,
  input wire [15:0] stack_top_ptr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Five context bytes, then the strobe drops
  sequence s_push5; stack_wr [*5] ##1 !stack_wr; endsequence
  a_sign_copy: assert property (alu_valid && !cc_wr |=>
    cond_code_reg[2] == $past(alu_result[7])) else $error("sign flag");
  a_zero_flag: assert property (alu_valid && !cc_wr |=>
    cond_code_reg[1] == ($past(alu_result) == 8'h00)) else $error("zero");
  a_carry_set: assert property (set_carry_op && !cc_wr |=>
    cond_code_reg[0]) else $error("carry set");
  a_carry_clr: assert property (
    clear_carry_op && !set_carry_op && !cc_wr |=> !cond_code_reg[0])
    else $error("carry clear");
  a_sp_high: assert property (stack_top_ptr[15:8] == 8'h01)
    else $error("pointer high byte");
  a_sp_reload: assert property (ptr_reload_op |=>
    stack_top_ptr == 16'h01ff) else $error("pointer reload");
  a_irq_prio: assert property (irq_enter && !seq_busy |=>
    {cond_code_reg[5], cond_code_reg[3]} == $past(irq_level_regs))
    else $error("priority load");
  a_int_push: assert property (
    irq_enter && !seq_busy |=> ##1 s_push5)
    else $error("interrupt push length");
  a_cc_top: assert property (cond_code_reg[7:6] == 2'b11)
    else $error("cc top bits");
endmodule
bind cfs_flags_sp cfs_flags_sp_monitor i_mon (.*);

// ==== tb/cpu_flags_and_stack_pointer_test.sv ====
// Self-checking bench for the flags and stack pointer block
`timescale 1ns/1ns
module cpu_flags_and_stack_pointer_test;
  reg ref_clk=0, rstn=0, alu_valid=0, alu_carry_upd=0, alu_carry=0;
  reg alu_half_upd=0, alu_half=0, set_carry_op=0, clear_carry_op=0;
  reg prio_wr=0, irq_enter=0, cc_wr=0, ptr_reload_op=0, sp_low_wr=0;
  reg push_byte=0, pop_byte=0, call_start=0, ret_start=0, int_return_op=0;
  reg [7:0] alu_result=0, cc_wr_data=0, sp_low_data=0, m_cc=8'he8, m_sp=8'hff;
  reg [1:0] prio_wr_val=0, irq_level_regs=0;
  reg [2:0] m_ctx;
  wire [7:0] cond_code_reg;
  wire [15:0] stack_top_ptr, stack_addr;
  wire stack_wr, seq_busy;
  wire [2:0] ctx_sel;
  integer errors=0, checks_done=0, seed=32'h20ae_ede1, i, k;
  cfs_flags_sp i_dut (.*);
  initial forever #25 ref_clk = ~ref_clk;
  task tick; begin @(posedge ref_clk); #5; end endtask
  task chk(input [23:0] s, e); begin
    checks_done = checks_done + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  end endtask
  task stop_test; begin
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  // Walks one push or pop sequence byte by byte
  task seq(input integer n, input integer up); begin
    tick; irq_enter=0; call_start=0; ret_start=0; int_return_op=0;
    chk(seq_busy, 1);
    for (k = 0; k < n; k = k + 1) begin
      tick;
      if (up) m_sp = m_sp + 1;
      m_ctx = up ? n - 1 - k : k;
      chk({stack_wr, m_ctx == ctx_sel, stack_addr},
          {!up, 1'b1, 8'h01, m_sp});
      if (!up) m_sp = m_sp - 1;
    end
    tick;
    chk({stack_wr, stack_top_ptr}, {1'b0, 8'h01, m_sp});
  end endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #5 rstn = 1;
    chk({cond_code_reg, stack_top_ptr}, {8'he8, 16'h01ff});
    for (i = 0; i < 40; i = i + 1) begin
      {alu_result, alu_carry, alu_half} = $random(seed);
      if (i == 5) alu_result = 8'h00;
      alu_valid = 1; alu_carry_upd = i[0]; alu_half_upd = i[1];
      set_carry_op = i[2]; clear_carry_op = i[3];
      m_cc[2] = alu_result[7];
      m_cc[1] = alu_result == 0;
      if (i[1]) m_cc[4] = alu_half;
      m_cc[0] = i[2] | !i[3] & (i[0] ? alu_carry : m_cc[0]);
      tick; chk(cond_code_reg, m_cc);
    end
    {alu_valid, alu_carry_upd, alu_half_upd, set_carry_op, clear_carry_op} = 0;
    for (i = 0; i < 4; i = i + 1) begin
      prio_wr = 1; prio_wr_val = i; {m_cc[5], m_cc[3]} = i;
      tick; chk(cond_code_reg, m_cc);
    end
    prio_wr = 0; irq_level_regs = $random(seed); irq_enter = 1;
    {m_cc[5], m_cc[3]} = irq_level_regs;
    seq(5, 0); chk(cond_code_reg, m_cc);
    int_return_op = 1; seq(5, 1);
    call_start = 1; seq(2, 0);
    ret_start = 1; seq(2, 1);
    cc_wr = 1; cc_wr_data = 8'h15;
    tick; chk(cond_code_reg, 8'hd5);
    cc_wr = 0; sp_low_wr = 1; sp_low_data = 8'h00;
    tick; chk(stack_top_ptr, 16'h0100);
    sp_low_wr = 0; push_byte = 1;
    tick; chk(stack_top_ptr, 16'h01ff);
    push_byte = 0; pop_byte = 1;
    tick; chk(stack_top_ptr, 16'h0100);
    pop_byte = 0; ptr_reload_op = 1;
    tick; chk(stack_top_ptr, 16'h01ff);
    ptr_reload_op = 0;
    tick; stop_test;
  end
endmodule
